// File: qdsl_top.sv
// Serial word intake, load strobe and clear logic of the quad converter.
`timescale 1ns/1ps
`default_nettype none
`include "qdsl_map.svh"
// Function
// - Each rising serial clock edge while the select is low shifts the data line into the serial input register.
// - While the select is high the data line is ignored and nothing is shifted.
// - The serial clock is not gated; the select enables the shift, so shifting happens only while it is low.
// - A falling load strobe copies the buffered words into the converter registers.
// - While clear is low the input and converter registers are forced to the clear code.
// - Clear never alters the serial input register.
// - The clear code is midscale 0x800 when the level select is high, else zero 0x000.
// - There are four independent channels A to D, each with its own converter register.
// - Each transfer carries one sixteen bit word over select, clock and data.
// - Converter codes are straight binary, all zeros meaning the negative reference.
module qdsl_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_chip_select_n,
    input wire logic i_serial_data_in,
    input wire logic i_load_outputs_n,
    input wire logic i_clear_n,
    input wire logic i_clear_level_select,
    output logic [11:0] o_channel_a_output,
    output logic [11:0] o_channel_b_output,
    output logic [11:0] o_channel_c_output,
    output logic [11:0] o_channel_d_output
);

    qdsl_pkg::qdsl_link_t link;
    qdsl_pkg::qdsl_link_t next_link;
    qdsl_pkg::qdsl_sys_t sys;
    qdsl_pkg::qdsl_sys_t next_sys;
    logic frame_end;
    logic load_fall;
    logic clear_on;
    logic [11:0] clear_val;
    logic [1:0] chan;

    // Picks the forced code for a clear from the level select.
    function automatic logic [11:0] clear_code(input logic sel);
        clear_code = sel ? `QDSL_CODE_MID : `QDSL_CODE_ZERO;
    endfunction

    // ************************************************************
    // Serial clock domain
    // ************************************************************

    // Shifts one bit per serial edge, most significant first, only while selected.
    always_comb
    begin
        next_link = link;
        if (!i_chip_select_n)
        begin
            next_link.shift = {link.shift[14:0], i_serial_data_in};
        end
    end

    // The shift register has no reset because the serial clock may stand still.
    // Clear logic lives in the other domain and never writes this register.
    always_ff @(posedge i_sclk)
    begin
        link <= next_link;
    end

    // Shifting follows the data line while selected.
    a_shift_in: assert property (@(posedge i_sclk) !$past(i_chip_select_n)
        |-> link.shift === {$past(link.shift[14:0]), $past(i_serial_data_in)})
        else $error("Serial bit was not shifted in.");

    // The newest bit always lands in the lowest position.
    a_shift_lsb: assert property (@(posedge i_sclk) !$past(i_chip_select_n)
        |-> link.shift[0] == $past(i_serial_data_in))
        else $error("Newest serial bit missing.");

    // A deselected clock edge leaves the word untouched.
    a_shift_hold: assert property (@(posedge i_sclk) $past(i_chip_select_n)
        |-> $stable(link.shift))
        else $error("Shift register moved while deselected.");

    // ************************************************************
    // System clock domain
    // ************************************************************

    // The shift register is read here without a synchroniser of its own.
    // This is safe only because the host stops the serial clock and keeps the
    // select high for several system cycles after a frame, so the word is still
    // when the synchronised select edge qualifies it.
    // A host that restarts a frame too soon can tear the captured word.
    // The load, clear and level pins each pass two flip-flops before use.

    // The word is read only after the synchronised select has risen, when it is still.
    assign frame_end = sys.cs_sync[1] && !sys.cs_prev;
    assign load_fall = !sys.ld_sync[1] && sys.ld_prev;
    assign clear_on = !sys.clr_sync[1];
    assign clear_val = clear_code(sys.sel_sync[1]);
    assign chan = link.shift[`QDSL_CHAN_MSB:`QDSL_CHAN_LSB];

    // Synchronises the pins, buffers words per channel and applies load and clear.
    always_comb
    begin
        next_sys = sys;
        next_sys.cs_sync = {sys.cs_sync[0], i_chip_select_n};
        next_sys.cs_prev = sys.cs_sync[1];
        next_sys.ld_sync = {sys.ld_sync[0], i_load_outputs_n};
        next_sys.ld_prev = sys.ld_sync[1];
        next_sys.clr_sync = {sys.clr_sync[0], i_clear_n};
        next_sys.sel_sync = {sys.sel_sync[0], i_clear_level_select};
        if (clear_on)
        begin
            for (int i = 0; i < `QDSL_CHAN_N; i++)
            begin
                next_sys.input_reg[i] = clear_val;
                next_sys.dac[i] = clear_val;
            end
        end
        else
        begin
            if (frame_end)
            begin
                next_sys.input_reg[chan] = link.shift[`QDSL_CODE_MSB:`QDSL_CODE_LSB];
            end
            if (load_fall)
            begin
                next_sys.dac = sys.input_reg;
            end
        end
    end

    // Registers the system state with a synchronous reset to idle pin levels.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sys.cs_sync <= 2'h3;
            sys.cs_prev <= 1'h1;
            sys.ld_sync <= 2'h3;
            sys.ld_prev <= 1'h1;
            sys.clr_sync <= 2'h3;
            sys.sel_sync <= 2'h0;
            sys.input_reg <= {`QDSL_CHAN_N{`QDSL_RST_CODE}};
            sys.dac <= {`QDSL_CHAN_N{`QDSL_RST_CODE}};
        end
        else
        begin
            sys <= next_sys;
        end
    end

    // Straight binary codes go out unchanged, one register per channel.
    assign o_channel_a_output = sys.dac[0];
    assign o_channel_b_output = sys.dac[1];
    assign o_channel_c_output = sys.dac[2];
    assign o_channel_d_output = sys.dac[3];

    // A held clear shows midscale when the select is high.
    a_clear_mid: assert property (@(posedge i_clk) disable iff (i_rst)
        clear_on && sys.sel_sync[1] |=> sys.dac[2] == 12'h800 && sys.input_reg[1] == 12'h800)
        else $error("Clear did not give midscale.");

    // A held clear shows zero when the select is low.
    a_clear_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        clear_on && !sys.sel_sync[1] |=> sys.dac[0] == 12'h000 && sys.dac[3] == 12'h000)
        else $error("Clear did not give zero scale.");

    // A load edge copies the buffered words into the converter registers.
    a_load_copy: assert property (@(posedge i_clk) disable iff (i_rst)
        load_fall && !clear_on |=> sys.dac == $past(sys.input_reg))
        else $error("Load did not copy the buffered words.");

    // Without a load edge or clear the converter registers hold.
    a_dac_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        !load_fall && !clear_on |=> $stable(sys.dac))
        else $error("Converter register changed without a cause.");

    // The end of a frame writes the addressed channel buffer.
    a_frame_write: assert property (@(posedge i_clk) disable iff (i_rst)
        frame_end && !clear_on && chan == 2'h1 |=> sys.input_reg[1] == $past(link.shift[11:0]))
        else $error("Frame word did not reach its channel.");

    // A load pin falling is seen as a load edge within one to three cycles.
    a_load_delay: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(i_load_outputs_n) |-> ##[1:3] load_fall)
        else $error("Load edge was not seen in time.");

    // ************************************************************
    // System clock domain checks
    // ************************************************************

    // The select synchroniser is a plain two stage pipe followed by the edge flop.
    a_cs_sync_pipe: assert property (@(posedge i_clk) disable iff (i_rst)
        sys.cs_sync[1] == $past(sys.cs_sync[0]) && sys.cs_prev == $past(sys.cs_sync[1]))
        else $error("Select synchroniser broke.");

    // The load synchroniser is a plain two stage pipe followed by the edge flop.
    a_ld_sync_pipe: assert property (@(posedge i_clk) disable iff (i_rst)
        sys.ld_sync[1] == $past(sys.ld_sync[0]) && sys.ld_prev == $past(sys.ld_sync[1]))
        else $error("Load synchroniser broke.");

    // The clear synchroniser is a plain two stage pipe.
    a_clr_sync_pipe: assert property (@(posedge i_clk) disable iff (i_rst)
        sys.clr_sync[1] == $past(sys.clr_sync[0]))
        else $error("Clear synchroniser broke.");

    // The level select synchroniser is a plain two stage pipe.
    a_sel_sync_pipe: assert property (@(posedge i_clk) disable iff (i_rst)
        sys.sel_sync[1] == $past(sys.sel_sync[0]))
        else $error("Level select synchroniser broke.");

    // A frame end lasts one cycle, so a word is captured once.
    a_frame_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
        frame_end |=> !frame_end)
        else $error("Frame end lasted too long.");

    // A load edge lasts one cycle, so a strobe copies once.
    a_load_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
        load_fall |=> !load_fall)
        else $error("Load edge lasted too long.");

    // A held clear forces every channel buffer to the clear code.
    a_clear_buf: assert property (@(posedge i_clk) disable iff (i_rst)
        clear_on |=> sys.input_reg == {`QDSL_CHAN_N{$past(clear_val)}})
        else $error("Clear did not force the buffers.");

    // A held clear forces every converter register to the clear code.
    a_clear_dac: assert property (@(posedge i_clk) disable iff (i_rst)
        clear_on |=> sys.dac == {`QDSL_CHAN_N{$past(clear_val)}})
        else $error("Clear did not force the converters.");

    // A zero level clear also zeroes the buffers.
    a_clear_zero_buf: assert property (@(posedge i_clk) disable iff (i_rst)
        clear_on && !sys.sel_sync[1] |=> sys.input_reg[2] == 12'h000)
        else $error("Clear did not zero the buffer.");

    // A frame arriving during clear is dropped.
    a_clear_frame: assert property (@(posedge i_clk) disable iff (i_rst)
        clear_on && frame_end |=> sys.input_reg == {`QDSL_CHAN_N{$past(clear_val)}})
        else $error("Frame got through a clear.");

    // A load arriving during clear is dropped.
    a_clear_load: assert property (@(posedge i_clk) disable iff (i_rst)
        clear_on && load_fall |=> sys.dac == {`QDSL_CHAN_N{$past(clear_val)}})
        else $error("Load got through a clear.");

    // A frame for channel A writes its buffer.
    a_frame_ch_a: assert property (@(posedge i_clk) disable iff (i_rst)
        frame_end && !clear_on && chan == 2'h0 |=> sys.input_reg[0] == $past(link.shift[11:0]))
        else $error("Frame word did not reach channel A.");

    // A frame for channel C writes its buffer.
    a_frame_ch_c: assert property (@(posedge i_clk) disable iff (i_rst)
        frame_end && !clear_on && chan == 2'h2 |=> sys.input_reg[2] == $past(link.shift[11:0]))
        else $error("Frame word did not reach channel C.");

    // A frame for channel D writes its buffer.
    a_frame_ch_d: assert property (@(posedge i_clk) disable iff (i_rst)
        frame_end && !clear_on && chan == 2'h3 |=> sys.input_reg[3] == $past(link.shift[11:0]))
        else $error("Frame word did not reach channel D.");

    // A frame for channel A leaves the other buffers alone.
    a_frame_others: assert property (@(posedge i_clk) disable iff (i_rst)
        frame_end && !clear_on && chan == 2'h0 |=> sys.input_reg[3:1] == $past(sys.input_reg[3:1]))
        else $error("Frame disturbed another channel.");

    // Without a frame or clear the buffers keep their words.
    a_buf_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        !frame_end && !clear_on |=> $stable(sys.input_reg))
        else $error("Channel buffer changed without a cause.");

    // A load drives the buffered word of channel A onto its output.
    a_load_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
        load_fall && !clear_on |=> o_channel_a_output == $past(sys.input_reg[0]))
        else $error("Channel A output missed the load.");

    // A load drives the buffered word of channel D onto its output.
    a_load_out_d: assert property (@(posedge i_clk) disable iff (i_rst)
        load_fall && !clear_on |=> o_channel_d_output == $past(sys.input_reg[3]))
        else $error("Channel D output missed the load.");

    // Reset leaves all converter registers at the reset code.
    a_reset_zero: assert property (@(posedge i_clk)
        i_rst |=> sys.dac == {`QDSL_CHAN_N{`QDSL_RST_CODE}})
        else $error("Reset did not zero the converters.");

    // Reset puts the synchronisers at idle pin levels, so no false edge follows.
    a_reset_idle: assert property (@(posedge i_clk)
        i_rst |=> sys.cs_sync == 2'h3 && sys.ld_sync == 2'h3 && sys.clr_sync == 2'h3)
        else $error("Reset did not idle the synchronisers.");

endmodule
`default_nettype wire

// File: qdsl_map.svh
// Constants for the quad converter serial load and clear front end.
`ifndef QDSL_MAP_SVH
`define QDSL_MAP_SVH
`define QDSL_WORD_W 16
`define QDSL_CODE_W 12
`define QDSL_CHAN_N 4
`define QDSL_CODE_LSB 0
`define QDSL_CODE_MSB 11
`define QDSL_CHAN_LSB 12
`define QDSL_CHAN_MSB 13
`define QDSL_CODE_ZERO 12'h000
`define QDSL_CODE_MID 12'h800
`define QDSL_RST_CODE 12'h000
`endif

// File: qdsl_pkg.sv
// Types for the quad converter serial load and clear front end.
package qdsl_pkg;
    // State held on the serial clock.
    typedef struct packed {
        logic [15:0] shift;
    } qdsl_link_t;
    // State held on the system clock.
    typedef struct packed {
        logic [1:0] cs_sync;
        logic cs_prev;
        logic [1:0] ld_sync;
        logic ld_prev;
        logic [1:0] clr_sync;
        logic [1:0] sel_sync;
        logic [3:0][11:0] input_reg;
        logic [3:0][11:0] dac;
    } qdsl_sys_t;
endpackage

// File: qdsl_host.sv
// Serial host model for the quad converter link.
`timescale 1ns/1ps
`default_nettype none
module qdsl_host (
    output logic o_sclk,
    output logic o_chip_select_n,
    output logic o_serial_data_in
);
    // Link idles with the clock still and the select high.
    initial
    begin
        o_sclk = 1'b0;
        o_chip_select_n = 1'b1;
        o_serial_data_in = 1'b0;
    end
    // Shifts one word MSB first; a high sel_n sends pulses meant to be ignored.
    task automatic send(input logic [15:0] w, input logic sel_n);
        o_chip_select_n = sel_n;
        for (int i = 15; i >= 0; i--)
        begin
            o_serial_data_in = w[i];
            #7.5 o_sclk = 1'b1;
            #7.5 o_sclk = 1'b0;
        end
        o_chip_select_n = 1'b1;
        o_serial_data_in = ~o_serial_data_in; // The released line keeps no stale bit.
        #500;
    endtask
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the quad converter serial load and clear front end.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic ld_n = 1'b1;
    logic clr_n = 1'b1;
    logic sel = 1'b0;
    logic sclk, cs_n, sdi;
    logic [11:0] oa, ob, oc, od;
    logic [47:0] expq[$];
    logic [47:0] last = 48'h0;
    logic [11:0] bufm[4] = '{default: 12'h000};
    int errors = 0;
    int checks_done = 0;
    // System clock.
    always #50 i_clk = ~i_clk;
    qdsl_host u_host (.o_sclk(sclk), .o_chip_select_n(cs_n), .o_serial_data_in(sdi));
    qdsl_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_chip_select_n(cs_n),
        .i_serial_data_in(sdi), .i_load_outputs_n(ld_n), .i_clear_n(clr_n),
        .i_clear_level_select(sel), .o_channel_a_output(oa), .o_channel_b_output(ob),
        .o_channel_c_output(oc), .o_channel_d_output(od));
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t outputs %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Writes a code into one channel buffer over the link.
    task automatic write(input logic [1:0] ch, input logic [11:0] code);
        u_host.send({2'b00, ch, code}, 1'b0);
        bufm[ch] = code;
    endtask
    // Pulses the load strobe and notes the outputs it should bring.
    task automatic load();
        expq.push_back({bufm[0], bufm[1], bufm[2], bufm[3]});
        @(posedge i_clk) #1 ld_n = 1'b0;
        repeat (3) @(posedge i_clk);
        #1 ld_n = 1'b1;
        repeat (8) @(posedge i_clk);
    endtask
    // Holds clear low with the given level select and notes the clear code.
    task automatic clear(input logic s);
        logic [11:0] c;
        c = s ? 12'h800 : 12'h000;
        bufm = '{default: c};
        expq.push_back({4{c}});
        @(posedge i_clk) #1 sel = s;
        clr_n = 1'b0;
        repeat (6) @(posedge i_clk);
        #1 clr_n = 1'b1;
        repeat (6) @(posedge i_clk);
    endtask
    // Takes the oldest note off the queue whenever the outputs change.
    always @(negedge i_clk)
        if (!i_rst && {oa, ob, oc, od} !== last)
        begin
            last <= {oa, ob, oc, od};
            check({oa, ob, oc, od}, expq.size() ? expq.pop_front() : last);
        end
    // Main sequence.
    initial
    begin
        void'($urandom(76361));
        repeat (4) @(posedge i_clk);
        #1 i_rst = 1'b0;
        check({oa, ob, oc, od}, 48'h0);
        $display("reset test done");
        for (int ch = 0; ch < 4; ch++)
            write(2'(ch), 12'($urandom));
        load();
        $display("load test done");
        write(2'h1, ~bufm[1]);
        u_host.send({4'h3, ~bufm[3]}, 1'b1);
        load();
        $display("select test done");
        clear(1'b0);
        clear(1'b1);
        write(2'h2, 12'($urandom) & 12'h7ff);
        load();
        $display("clear test done");
        check(48'(expq.size()), 48'h0);
        stop_test();
    end
    // Cuts a hang short.
    initial
    begin
        #100000;
        errors++;
        stop_test();
    end
endmodule
`default_nettype wire
